// File: flash_crc_pkg.sv
// Purpose: shared constants and types for the bulk flash crc checker
// Assumes: one 250 MHz clock, synchronous active-high reset
// Notes:   control register layout is a local choice, see handover
package flash_crc_pkg;

  // ==========================================================
  // control register layout
  localparam int         CTL_WIDTH      = 8;
  localparam int         CTL_EN_BIT     = 7;
  localparam int         CTL_RANGE_LSB  = 0;
  localparam int         CTL_RANGE_W    = 3;
  localparam logic [7:0] CTL_RESET      = 8'h00;

  // ==========================================================
  // crc constants
  localparam int          CRC_W         = 16;
  localparam logic [15:0] CRC_POLY      = 16'h1021;
  localparam logic [15:0] CRC_SEED      = 16'h0000;
  localparam logic [15:0] RESULT_RESET  = 16'h0000;
  localparam int          WORD_W        = 32;

  // ==========================================================
  // flash word addressing, range = (1 << range) kilowords
  localparam int          ADDR_W        = 17;
  localparam int          RANGE_BASE_SH = 10;

  typedef struct packed {
    logic        en;
    logic [3:0]  unused;
    logic [2:0]  range;
  } crc_ctl_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_DONE = 3'b100
  } crc_state_t;

endpackage

// File: flash_bulk_crc_checker.sv
// Purpose: fast whole-flash crc check while the cpu is halted
// Assumes: flash returns a 32-bit word one cycle after its address
// Notes:   control writes by byte or by single bit
// Notes:   range field picks 1K words times a power of two
// Notes:   result tracks the running crc, final once busy drops
`timescale 1ns/1ps
module flash_bulk_crc_checker
  import flash_crc_pkg::*;
(
  input  wire logic              clk_i,          // system clock
  input  wire logic              rst_i,          // sync reset, high
  input  wire logic              ctl_wr_byte_i,  // byte write strobe
  input  wire logic [7:0]        ctl_wdata_i,    // byte write data
  input  wire logic              ctl_wr_bit_i,   // single bit write strobe
  input  wire logic [2:0]        ctl_bit_sel_i,  // bit index
  input  wire logic              ctl_bit_val_i,  // bit value
  input  wire logic              cpu_halted_i,   // cpu in halt on main clock
  input  wire logic              run_from_ram_i, // code executes from ram
  input  wire logic [WORD_W-1:0] flash_rdata_i,  // flash word, one cycle late
  output logic [ADDR_W-1:0]      flash_addr_o,   // flash word address
  output logic                   flash_rd_o,     // flash read strobe
  output logic [CTL_WIDTH-1:0]   ctl_rdata_o,    // control readback
  output logic [CRC_W-1:0]       result_o,       // crc result
  output logic                   busy_o,         // check in progress
  output logic                   halt_release_o  // cpu may leave halt
);

  // ==========================================================
  // crc step over one word, msb first
  function automatic logic [CRC_W-1:0] crc_word(input logic [CRC_W-1:0] c,
                                                 input logic [WORD_W-1:0] d);
    logic [CRC_W-1:0] r;
    logic             fb;
    r = c;
    for (int i = WORD_W-1; i >= 0; i--) begin
      fb = r[CRC_W-1] ^ d[i];
      r  = {r[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
    end
    return r;
  endfunction

  // ==========================================================
  // control register
  logic [CTL_WIDTH-1:0] flash_crc_control_reg;
  logic [CTL_WIDTH-1:0] flash_crc_control_next;
  logic [CRC_W-1:0]     flash_crc_result_reg;
  logic [CRC_W-1:0]     crc_reg;
  logic [ADDR_W-1:0]    addr_reg;
  logic                 data_vld_reg;
  logic                 last_vld_reg;
  crc_state_t           state_reg;
  crc_state_t           state_next;
  crc_ctl_t             ctl;
  wire logic [ADDR_W:0] range_words;
  wire logic            allowed;
  wire logic            last_addr;
  wire logic            fetch;

  assign ctl = crc_ctl_t'(flash_crc_control_reg);

  always_comb begin
    flash_crc_control_next = flash_crc_control_reg;
    if (ctl_wr_byte_i) begin
      flash_crc_control_next = ctl_wdata_i;
    end else if (ctl_wr_bit_i) begin
      flash_crc_control_next[ctl_bit_sel_i] = ctl_bit_val_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_crc_control_reg <= CTL_RESET;
    end else begin
      flash_crc_control_reg <= flash_crc_control_next;
    end
  end

  // ==========================================================
  // sequencing
  assign range_words = (ADDR_W+1)'(1) << (RANGE_BASE_SH + int'(ctl.range));
  assign allowed     = cpu_halted_i && run_from_ram_i;
  assign last_addr   = ({1'b0, addr_reg} == range_words - (ADDR_W+1)'(1));
  assign fetch       = (state_reg == ST_RUN) && allowed;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (ctl.en && allowed) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!ctl.en) begin
          state_next = ST_IDLE;
        end else if (fetch && last_addr) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!ctl.en) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg    <= ST_IDLE;
      addr_reg     <= '0;
      data_vld_reg <= 1'b0;
      last_vld_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      data_vld_reg <= fetch;
      last_vld_reg <= fetch && last_addr;
      if (state_reg == ST_IDLE) begin
        addr_reg <= '0;
      end else if (fetch) begin
        addr_reg <= addr_reg + (ADDR_W)'(1);
      end
    end
  end

  // ==========================================================
  // crc accumulation and result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crc_reg              <= CRC_SEED;
      flash_crc_result_reg <= RESULT_RESET;
    end else begin
      if (state_reg == ST_IDLE && state_next == ST_RUN) begin
        crc_reg <= CRC_SEED;
      end else if (data_vld_reg) begin
        crc_reg <= crc_word(crc_reg, flash_rdata_i);
      end
      if (data_vld_reg) begin
        flash_crc_result_reg <= crc_word(crc_reg, flash_rdata_i);
      end
    end
  end

  assign flash_addr_o   = addr_reg;
  assign flash_rd_o     = fetch;
  assign ctl_rdata_o    = flash_crc_control_reg;
  assign result_o       = flash_crc_result_reg;
  assign busy_o         = (state_reg == ST_RUN) || data_vld_reg;
  assign halt_release_o = (state_reg != ST_RUN) && !data_vld_reg;

  // ==========================================================
  // checks
  AST_NO_FETCH_UNLESS_HALTED: assert property (@(posedge clk_i) disable iff (rst_i)
    flash_rd_o |-> (cpu_halted_i && run_from_ram_i))
    else $error("fetch outside halt");
  AST_ADDR_STEPS: assert property (@(posedge clk_i) disable iff (rst_i)
    (flash_rd_o && !last_addr) ##1 flash_rd_o |-> flash_addr_o == $past(flash_addr_o) + 1'b1)
    else $error("address did not step");
  AST_CRC_FOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    data_vld_reg |=> result_o == crc_word($past(crc_reg), $past(flash_rdata_i)))
    else $error("crc fold wrong");
  AST_MSB_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
    crc_word(16'h0000, 32'h0000_0001) == 16'h1021)
    else $error("bit order wrong");
  AST_STOP_ON_DISABLE: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctl.en ##1 !ctl.en |-> !flash_rd_o)
    else $error("fetch while disabled");
  AST_CTL_BYTE: assert property (@(posedge clk_i) disable iff (rst_i)
    ctl_wr_byte_i |=> ctl_rdata_o == $past(ctl_wdata_i))
    else $error("byte write lost");
  AST_RESULT_AFTER_LAST: assert property (@(posedge clk_i) disable iff (rst_i)
    last_vld_reg |=> result_o == crc_reg)
    else $error("result not updated");
  AST_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i)
    (flash_rd_o && last_addr && ctl.en) |=> ##1 (halt_release_o && !flash_rd_o))
    else $error("no release after last word");

  // ==========================================================
  // reset, control and sequencing checks
  AST_RESET_CLEAR: assert property (@(posedge clk_i)
    rst_i |=> (ctl_rdata_o == CTL_RESET && result_o == RESULT_RESET && !flash_rd_o && halt_release_o))
    else $error("reset did not clear");
  AST_CTL_BIT: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctl_wr_bit_i && !ctl_wr_byte_i) |=> ctl_rdata_o[$past(ctl_bit_sel_i)] == $past(ctl_bit_val_i))
    else $error("bit write lost");
  AST_CTL_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ctl_wr_byte_i && !ctl_wr_bit_i) |=> $stable(ctl_rdata_o))
    else $error("control changed without write");
  AST_START_ALLOWED: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(busy_o) |-> $past(cpu_halted_i && run_from_ram_i))
    else $error("check started outside halt");
  AST_START_AT_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(busy_o) |-> flash_addr_o == '0)
    else $error("check did not start at word zero");
  AST_PAUSE_HOLDS_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
    ((state_reg != ST_IDLE) && !flash_rd_o) |=> $stable(flash_addr_o))
    else $error("address moved without fetch");
  AST_RESULT_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !data_vld_reg |=> $stable(result_o))
    else $error("result moved without data");
  AST_RESULT_AFTER_FETCH: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(result_o) |-> $past(flash_rd_o, 2))
    else $error("result changed without a fetch");
  AST_RANGE_END: assert property (@(posedge clk_i) disable iff (rst_i)
    last_vld_reg |-> state_reg != ST_RUN)
    else $error("still running after last word");
  AST_DONE_NO_REFETCH: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_DONE) |=> state_reg != ST_RUN)
    else $error("restart without disable");
  AST_RELEASE_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
    halt_release_o |-> (!flash_rd_o && !busy_o))
    else $error("release while fetching");

endmodule

// File: flash_word_model.sv
// Purpose: behavioural code flash answering the crc engine
// Assumes: word valid the cycle after the read strobe
// Notes:   outside reads the data bus toggles every cycle
`timescale 1ns/1ps
module flash_word_model
  import flash_crc_pkg::*;
(
  input  wire logic              clk_i,   // system clock
  input  wire logic              rd_i,    // read strobe
  input  wire logic [ADDR_W-1:0] addr_i,  // word address
  output logic      [WORD_W-1:0] rdata_o  // word, one cycle late
);
  // ==========================================================
  // array contents are an address pattern, idle data is junk
  initial rdata_o = 32'h0000_0000;
  always @(posedge clk_i) begin
    if (rd_i) begin
      rdata_o <= {addr_i[15:0], ~addr_i[15:0]} ^ 32'h5a3c_96e1;
    end else begin
      rdata_o <= ~rdata_o;
    end
  end
endmodule

// File: tb.sv
// Purpose: self-checking bench for the bulk flash crc checker
// Assumes: 250 MHz clock, sync active-high reset
// Notes:   expected crc rebuilt here from the flash pattern
`timescale 1ns/1ps
module tb
  import flash_crc_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, wr_b = 1'b0, wr_t = 1'b0, bval = 1'b0;
  logic halted = 1'b0, ram = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [2:0] bsel = 3'h0;
  logic [WORD_W-1:0] rdata;
  logic [ADDR_W-1:0] addr;
  logic rd, busy, rel;
  logic [7:0] ctl;
  logic [CRC_W-1:0] res;
  int num_errors = 0, cmp_count = 0, rd_cnt = 0;
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) if (rd === 1'b1) rd_cnt++;
  flash_bulk_crc_checker u_flash_bulk_crc_checker (.clk_i(clk_i), .rst_i(rst_i), .ctl_wr_byte_i(wr_b),
    .ctl_wdata_i(wdata), .ctl_wr_bit_i(wr_t), .ctl_bit_sel_i(bsel), .ctl_bit_val_i(bval),
    .cpu_halted_i(halted), .run_from_ram_i(ram), .flash_rdata_i(rdata), .flash_addr_o(addr),
    .flash_rd_o(rd), .ctl_rdata_o(ctl), .result_o(res), .busy_o(busy), .halt_release_o(rel));
  flash_word_model u_flash_word_model (.clk_i(clk_i), .rd_i(rd), .addr_i(addr), .rdata_o(rdata));
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wbyte(input logic [7:0] v);
    @(posedge clk_i); wr_b <= 1'b1; wdata <= v;
    @(posedge clk_i); wr_b <= 1'b0;
    #1;
  endtask
  task automatic wbit(input logic [2:0] s, input logic v);
    @(posedge clk_i); wr_t <= 1'b1; bsel <= s; bval <= v;
    @(posedge clk_i); wr_t <= 1'b0;
    #1;
  endtask
  function automatic logic [15:0] exp_crc(input int words);
    logic [15:0] c;
    logic [31:0] d;
    c = 16'h0000;
    for (int a = 0; a < words; a++) begin
      d = {a[15:0], ~a[15:0]} ^ 32'h5a3c_96e1;
      for (int i = 31; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
  task automatic end_of_test();
    if (num_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_ctl();
    chk(ctl, 8'h00, "ctl reset");
    chk({busy, rel, res}, {2'b01, 16'h0000}, "idle reset");
    wbyte(8'h05);
    wbit(3'h7, 1'b1);
    chk(ctl, 8'h85, "bit set");
    wbit(3'h2, 1'b0);
    chk(ctl, 8'h81, "bit clear");
    repeat (20) @(posedge clk_i);
    chk(rd_cnt, 0, "ran while not halted");
  endtask
  task automatic t_run();
    logic [15:0] c;
    c = exp_crc(2048);
    @(posedge clk_i); halted <= 1'b1; ram <= 1'b1;
    for (int n = 0; n < 3000; n++) begin
      @(posedge clk_i); #1;
      if (busy === 1'b0 && rd_cnt > 0) break;
    end
    chk(rd_cnt, 2048, "word count");
    chk(res, c, "crc result");
    chk({busy, rel}, 2'b01, "release after last word");
  endtask
  task automatic t_abort();
    wbyte(8'h00);
    wbyte(8'h80);
    repeat (50) @(posedge clk_i);
    #1;
    chk(busy, 1'b1, "restart");
    wbyte(8'h00);
    repeat (2) @(posedge clk_i);
    #1;
    chk({busy, rd, addr}, 19'h00000, "abort");
  endtask
  task automatic t_gate();
    int n0;
    int n1;
    @(posedge clk_i); ram <= 1'b0;
    wbyte(8'h80);
    n0 = rd_cnt;
    repeat (10) @(posedge clk_i);
    #1;
    chk(rd_cnt - n0, 0, "ran outside ram");
    chk({busy, rel}, 2'b01, "idle outside ram");
    @(posedge clk_i); ram <= 1'b1;
    repeat (100) @(posedge clk_i);
    halted <= 1'b0;
    @(posedge clk_i); #1;
    n1 = rd_cnt;
    repeat (5) @(posedge clk_i);
    #1;
    chk(rd_cnt - n1, 0, "fetch while awake");
    chk({busy, rel, rd}, 3'b100, "pause holds");
    @(posedge clk_i); halted <= 1'b1;
    for (int n = 0; n < 1200; n++) begin
      @(posedge clk_i); #1;
      if (busy === 1'b0) break;
    end
    chk(rd_cnt - n0, 1024, "resumed count");
    chk(res, exp_crc(1024), "range 0 crc");
    chk({busy, rel}, 2'b01, "release after resume");
  endtask
  task automatic t_reset();
    wbyte(8'h00);
    wbyte(8'h87);
    repeat (20) @(posedge clk_i);
    #1;
    chk({busy, rd}, 2'b11, "long run");
    @(posedge clk_i); rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i); #1;
    chk(ctl, 8'h00, "ctl after reset");
    chk(addr, 0, "addr after reset");
    chk({busy, rel, rd, res}, {3'b010, 16'h0000}, "idle after reset");
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i); #1;
    t_ctl();
    t_run();
    t_abort();
    t_gate();
    t_reset();
    end_of_test();
  end
  initial begin
    #40000;
    num_errors++;
    end_of_test();
  end
endmodule
